// file: design/cpu_bus_ready_irq_control.sv
// Purpose: Bus cycle, ready stall and maskable interrupt control of an 8-bit processor.
// Assumes: The core holds a request until accepted and flags its last instruction cycle.
// Notes: Pins are sampled through three flip-flops; the core side is synchronous.
// Contract
// [RULE1] External variant runs on supplied two-phase clock.
// [RULE2] Internal variant makes both phases on chip.
// [RULE3] Full configuration drives sixteen address lines.
// [RULE4] Mid configuration drives thirteen address lines.
// [RULE5] Small configuration drives twelve address lines.
// [RULE6] Eight-bit data bus, driven and received.
// [RULE7] Data drivers released unless driving write data.
// [RULE8] Gate input high enables data drivers.
// [RULE9] System drives gate from phase two.
// [RULE10] Drivers off in every read cycle.
// [RULE11] Outside agent holds gate low to release.
// [RULE12] Ready stalls any cycle except writes.
// [RULE13] Ready low in phase one halts, address held.
// [RULE14] Ready low on write defers to next read.
// [RULE15] Halt lasts while ready low at phase two.
// [RULE16] Interrupt taken only after instruction completes.
// [RULE17] Interrupt starts only with mask flag clear.
// [RULE18] Sequence pushes program counter and status.
// [RULE19] Mask flag set after state saved.
// [RULE20] Vector fetched from FFFE then FFFF.
// [RULE21] Interrupt recognised only while ready high.
// [RULE22] Interrupt sampled in phase two, starts phase one.
// [RULE23] Push order high, low, status; stack decrements.
`timescale 1ns/10ps
`default_nettype none
`include "cpu_bus_regs.svh"

module cpu_bus_ready_irq_control #(
  parameter bit EXT_CLOCK = 1'b0,
  parameter bit HAS_GATE = 1'b0,
  parameter int ADDR_W = 16,
  parameter int PHASE_CYC = `PHASE_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Clock pins
  input wire logic phi1_i,
  input wire logic phi2_i,
  output logic phi1_o,
  output logic phi2_o,
  // Bus pins
  output logic [ADDR_W-1:0] addr_out_o,
  input wire logic [7:0] data_io_i,
  output logic [7:0] data_io_o,
  output logic data_io_oe_o,
  output logic write_o,
  input wire logic data_out_gate_i,
  input wire logic ready_i,
  input wire logic irq_n_i,
  // Core side
  input wire cpu_bus_pkg::bus_req_s req_i,
  output logic req_ready_o,
  output cpu_bus_pkg::bus_rsp_s rsp_o,
  input wire logic mask_flag_i,
  input wire logic [15:0] pc_i,
  input wire logic [7:0] status_i,
  input wire logic [7:0] sp_i,
  output logic mask_set_o,
  output cpu_bus_pkg::irq_done_s irq_done_o,
  output logic irq_busy_o,
  output logic halted_o
);

  localparam int SYNC_W = 11;

  logic phi2;
  logic p1_start;
  logic p1_end;
  logic p2_end;
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] sa_q;
  logic [SYNC_W-1:0] sb_q;
  logic [SYNC_W-1:0] sc_q;
  logic [SYNC_W-1:0] pin_q;
  logic ready_s;
  logic irq_low_s;
  logic gate_s;
  logic [7:0] din_s;
  logic cyc_q;
  logic wr_q;
  logic last_q;
  logic [15:0] addr_q;
  logic [7:0] wdata_q;
  logic halt_q;
  logic done;
  logic irq_pend_q;
  logic irq_start;
  logic from_irq_q;
  cpu_bus_pkg::irq_state_e irq_st_q;
  logic [7:0] sp_q;
  logic [15:0] pc_cap_q;
  logic [7:0] p_cap_q;
  logic [7:0] vec_lo_q;
  logic gate_ok;

  // ----------------------------------------
  // Phase source
  // ----------------------------------------
  phase_clock_gen #(
    .EXT_CLOCK(EXT_CLOCK),
    .PHASE_CYC(PHASE_CYC)
  ) u_phase (
    .sys_clk_i(sys_clk_i), // [RULE1] [RULE2]
    .reset_i(reset_i),
    .phi1_i(phi1_i),
    .phi2_i(phi2_i),
    .phi1_o(phi1_o),
    .phi2_o(phi2),
    .p1_start_o(p1_start),
    .p1_end_o(p1_end),
    .p2_end_o(p2_end)
  );
  assign phi2_o = phi2;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  assign raw = {data_io_i, irq_n_i, data_out_gate_i, ready_i};

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      sa_q <= '0;
      sb_q <= '0;
      sc_q <= '0;
    end
    else
    begin
      sa_q <= raw;
      sb_q <= sa_q;
      sc_q <= sb_q;
    end
  end

  // A level counts only once two stages agree, which filters a one-cycle glitch.
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++)
    begin : g_pin
      always_ff @(posedge sys_clk_i)
      begin
        if (reset_i)
          pin_q[gi] <= (gi == 2);
        else if (sb_q[gi] == sc_q[gi])
          pin_q[gi] <= sb_q[gi];
      end
    end
  endgenerate

  assign ready_s = pin_q[0];
  assign gate_s = pin_q[1];
  assign irq_low_s = !pin_q[2];
  assign din_s = pin_q[10:3]; // [RULE6]

  // ----------------------------------------
  // Bus cycle
  // ----------------------------------------
  // Writes never wait; a read completes only on a phase two end with ready high.
  assign done = cyc_q && p2_end && (wr_q || ready_s); // [RULE12] [RULE14] [RULE15]

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      cyc_q <= 1'b0;
      wr_q <= 1'b0;
      last_q <= 1'b0;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      from_irq_q <= 1'b0;
    end
    else if (done)
      cyc_q <= 1'b0;
    else if (p1_start && !cyc_q)
    begin
      // A stalled cycle stays in place, so its address is repeated. [RULE13]
      if (irq_st_q != cpu_bus_pkg::IRQ_IDLE)
      begin
        cyc_q <= 1'b1;
        from_irq_q <= 1'b1;
        last_q <= 1'b0;
        unique case (irq_st_q)
          cpu_bus_pkg::IRQ_PUSH_PCH:
          begin
            wr_q <= 1'b1;
            addr_q <= {`STACK_PAGE, sp_q};
            wdata_q <= pc_cap_q[15:8];
          end
          cpu_bus_pkg::IRQ_PUSH_PCL:
          begin
            wr_q <= 1'b1;
            addr_q <= {`STACK_PAGE, sp_q};
            wdata_q <= pc_cap_q[7:0];
          end
          cpu_bus_pkg::IRQ_PUSH_P:
          begin
            wr_q <= 1'b1;
            addr_q <= {`STACK_PAGE, sp_q};
            wdata_q <= p_cap_q;
          end
          cpu_bus_pkg::IRQ_VEC_LO:
          begin
            wr_q <= 1'b0;
            addr_q <= `IRQ_VEC_LO; // [RULE20]
          end
          default:
          begin
            wr_q <= 1'b0;
            addr_q <= `IRQ_VEC_HI; // [RULE20]
          end
        endcase
      end
      else if (req_i.valid)
      begin
        cyc_q <= 1'b1;
        from_irq_q <= 1'b0;
        wr_q <= req_i.write;
        last_q <= req_i.last;
        addr_q <= req_i.addr;
        wdata_q <= req_i.wdata;
      end
    end
  end

  // Halt marks a read held by ready low at the end of phase one.
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i || done)
      halt_q <= 1'b0;
    else if (cyc_q && !wr_q && p1_end && !ready_s)
      halt_q <= 1'b1; // [RULE13]
  end

  assign req_ready_o = p1_start && !cyc_q && irq_st_q == cpu_bus_pkg::IRQ_IDLE;
  assign addr_out_o = addr_q[ADDR_W-1:0]; // [RULE3] [RULE4] [RULE5]
  assign write_o = cyc_q && wr_q;
  assign halted_o = halt_q;
  assign irq_busy_o = irq_st_q != cpu_bus_pkg::IRQ_IDLE;

  // ----------------------------------------
  // Data drivers
  // ----------------------------------------
  assign gate_ok = HAS_GATE ? gate_s : 1'b1; // [RULE8] [RULE11]
  assign data_io_oe_o = cyc_q && wr_q && phi2 && gate_ok; // [RULE7] [RULE10] [RULE9]
  assign data_io_o = wdata_q;

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      rsp_o <= '0;
    else
    begin
      rsp_o.valid <= done && !from_irq_q;
      if (done && !wr_q)
        rsp_o.rdata <= din_s;
    end
  end

  // ----------------------------------------
  // Maskable interrupt
  // ----------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      irq_pend_q <= 1'b0;
    else if (p2_end)
      irq_pend_q <= irq_low_s; // [RULE22]
  end

  // Taken at the end of an instruction, so the sequence opens on the next phase one.
  assign irq_start = done && last_q && !from_irq_q && irq_pend_q && !mask_flag_i
    && ready_s; // [RULE16] [RULE17] [RULE21]

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      irq_st_q <= cpu_bus_pkg::IRQ_IDLE;
      sp_q <= 8'h00;
      pc_cap_q <= 16'h0000;
      p_cap_q <= 8'h00;
      vec_lo_q <= 8'h00;
    end
    else if (irq_start)
    begin
      irq_st_q <= cpu_bus_pkg::IRQ_PUSH_PCH; // [RULE18]
      sp_q <= sp_i;
      pc_cap_q <= pc_i;
      p_cap_q <= status_i;
    end
    else if (done && from_irq_q)
    begin
      unique case (irq_st_q)
        cpu_bus_pkg::IRQ_PUSH_PCH:
        begin
          irq_st_q <= cpu_bus_pkg::IRQ_PUSH_PCL; // [RULE23]
          sp_q <= sp_q - 8'h01;
        end
        cpu_bus_pkg::IRQ_PUSH_PCL:
        begin
          irq_st_q <= cpu_bus_pkg::IRQ_PUSH_P; // [RULE23]
          sp_q <= sp_q - 8'h01;
        end
        cpu_bus_pkg::IRQ_PUSH_P:
        begin
          irq_st_q <= cpu_bus_pkg::IRQ_VEC_LO;
          sp_q <= sp_q - 8'h01;
        end
        cpu_bus_pkg::IRQ_VEC_LO:
        begin
          irq_st_q <= cpu_bus_pkg::IRQ_VEC_HI;
          vec_lo_q <= din_s;
        end
        default:
          irq_st_q <= cpu_bus_pkg::IRQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      mask_set_o <= 1'b0;
      irq_done_o <= '0;
    end
    else
    begin
      mask_set_o <= done && irq_st_q == cpu_bus_pkg::IRQ_PUSH_P; // [RULE19]
      irq_done_o.valid <= done && irq_st_q == cpu_bus_pkg::IRQ_VEC_HI;
      if (done && irq_st_q == cpu_bus_pkg::IRQ_VEC_HI)
      begin
        irq_done_o.pc <= {din_s, vec_lo_q}; // [RULE20]
        irq_done_o.sp <= sp_q;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_pch_done;
    done && irq_st_q == cpu_bus_pkg::IRQ_PUSH_PCH;
  endsequence

  sequence s_pcl_next;
    irq_st_q == cpu_bus_pkg::IRQ_PUSH_PCL && sp_q == $past(sp_q) - 8'h01;
  endsequence

  a_read_drv_off: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RULE10]
    cyc_q && !wr_q |-> !data_io_oe_o)
    else $error("data drivers on during read");

  a_gate_low_off: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RULE8]
    HAS_GATE && !gate_s |-> !data_io_oe_o)
    else $error("data drivers on with gate low");

  a_write_no_halt: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RULE14]
    cyc_q && wr_q && p2_end |=> !cyc_q && !halt_q)
    else $error("write cycle stalled");

  a_halt_addr_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RULE13]
    halt_q && $past(halt_q) |-> $stable(addr_out_o))
    else $error("address moved while halted");

  a_halt_persists: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RULE15]
    halt_q && p2_end && !ready_s |=> halt_q && cyc_q)
    else $error("halt left with ready low");

  a_push_order: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RULE23]
    s_pch_done |=> s_pcl_next)
    else $error("push order or stack step wrong");

  a_vector_addr: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RULE20]
    cyc_q && irq_st_q == cpu_bus_pkg::IRQ_VEC_LO |-> addr_q == `IRQ_VEC_LO)
    else $error("low vector address wrong");

  a_mask_after_save: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RULE19]
    mask_set_o |-> $past(irq_st_q) == cpu_bus_pkg::IRQ_PUSH_P && $past(wr_q))
    else $error("mask set before state saved");

  a_irq_gated: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RULE17]
    irq_start |-> !mask_flag_i && ready_s ##1 irq_st_q == cpu_bus_pkg::IRQ_PUSH_PCH)
    else $error("interrupt started while masked");

endmodule
`default_nettype wire

// file: include/cpu_bus_regs.svh
// Purpose: Timing counts and fixed addresses for the bus and interrupt control block.
// Assumes: System clock of 20 MHz, a period of 50 ns.
// Notes: Addresses are full 16-bit values and are cut to the bus width at the pins.
`ifndef CPU_BUS_REGS_SVH
`define CPU_BUS_REGS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define SYS_PERIOD_NS 50
`define PHASE_NS 250
`define PHASE_CYC ((`PHASE_NS) / (`SYS_PERIOD_NS))

// ----------------------------------------
// Addresses
// ----------------------------------------
`define IRQ_VEC_LO 16'hFFFE
`define IRQ_VEC_HI 16'hFFFF
`define STACK_PAGE 8'h01

`endif

// file: include/cpu_bus_pkg.sv
// Purpose: Types shared by the bus and interrupt control block.
// Assumes: Nothing beyond the block's own files.
// Notes: Structs carry grouped signals between core and block.
package cpu_bus_pkg;

  // ----------------------------------------
  // Core side carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic last;
    logic [15:0] addr;
    logic [7:0] wdata;
  } bus_req_s;

  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
  } bus_rsp_s;

  typedef struct packed {
    logic valid;
    logic [15:0] pc;
    logic [7:0] sp;
  } irq_done_s;

  // ----------------------------------------
  // Interrupt sequence
  // ----------------------------------------
  typedef enum logic [2:0] {
    IRQ_IDLE,
    IRQ_PUSH_PCH,
    IRQ_PUSH_PCL,
    IRQ_PUSH_P,
    IRQ_VEC_LO,
    IRQ_VEC_HI
  } irq_state_e;

endpackage

// file: design/phase_clock_gen.sv
// Purpose: Two-phase clock source, made on chip or taken from pins.
// Assumes: External phases do not overlap and are slower than 4 system clocks each.
// Notes: Emits one-cycle strobes that mark the phase edges for the bus logic.
`timescale 1ns/10ps
`default_nettype none
`include "cpu_bus_regs.svh"

module phase_clock_gen #(
  parameter bit EXT_CLOCK = 1'b0,
  parameter int PHASE_CYC = `PHASE_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // External phase pins
  input wire logic phi1_i,
  input wire logic phi2_i,
  // Phase levels and strobes
  output logic phi1_o,
  output logic phi2_o,
  output logic p1_start_o,
  output logic p1_end_o,
  output logic p2_end_o
);

  logic [15:0] cnt_q;
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic ph1_q;
  logic ph2_q;
  logic ph1_prev_q;
  logic ph2_prev_q;

  // ----------------------------------------
  // Internal divider from the time base
  // ----------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i || cnt_q == 16'(2 * PHASE_CYC - 1))
      cnt_q <= 16'h0000;
    else
      cnt_q <= cnt_q + 16'h0001;
  end

  // ----------------------------------------
  // Pin phases: three stages, change taken when stages two and three agree
  // ----------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
      ph1_q <= 1'b0;
      ph2_q <= 1'b0;
      ph1_prev_q <= 1'b0;
      ph2_prev_q <= 1'b0;
    end
    else
    begin
      s1_q <= {phi2_i, phi1_i, 1'b0};
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q[1] == s3_q[1])
        ph1_q <= s2_q[1];
      if (s2_q[2] == s3_q[2])
        ph2_q <= s2_q[2];
      ph1_prev_q <= phi1_o;
      ph2_prev_q <= phi2_o;
    end
  end

  // Internal phases leave a dead cycle-free split; external ones keep their own gap.
  always_comb
  begin
    if (EXT_CLOCK)
    begin
      phi1_o = ph1_q;
      phi2_o = ph2_q;
    end
    else
    begin
      phi1_o = (cnt_q < 16'(PHASE_CYC));
      phi2_o = !phi1_o;
    end
    p1_start_o = phi1_o && !ph1_prev_q;
    p1_end_o = !phi1_o && ph1_prev_q;
    p2_end_o = !phi2_o && ph2_prev_q;
  end

endmodule
`default_nettype wire

// file: sim/bus_memory_model.sv
// Purpose: Memory and peripheral space on the far side of the processor bus.
// Assumes: Phase two level comes from the block; addresses are full 16-bit values.
// Notes: A released data bus shows the inverse of its last level, never a held copy.
`timescale 1ns/10ps
`default_nettype none

module bus_memory_model (
  // Clock
  input wire logic sys_clk_i,
  // Bus from the block
  input wire logic phi2_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic oe_i,
  input wire logic write_i,
  // System control
  input wire logic hold_off_i,
  // Back to the block
  output logic [7:0] data_o,
  output logic gate_o
);
  // --------------------------------------
  // Storage and bus level
  // --------------------------------------
  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'h00;

  // The gate follows phase two, and a bus-stealing agent pulls it low.
  assign gate_o = phi2_i & ~hold_off_i;

  // Memory answers in phase two whenever no write is on; a driven write wins, otherwise the bus floats.
  assign data_o = oe_i ? wdata_i : (!write_i && phi2_i) ? mem[addr_i] : ~last_q;

  always @(posedge sys_clk_i)
  begin
    if (oe_i)
    begin
      mem[addr_i] <= wdata_i;
    end
    last_q <= data_o;
  end
endmodule

`default_nettype wire

// file: sim/testbench.sv
// Purpose: Self-checking bench for bus cycles, ready stalls and the maskable interrupt.
// Assumes: On-chip phases, gated data drivers, full 16-bit address bus.
// Notes: Outputs are sampled at the falling edge; requests change at the rising edge, other inputs partly at the falling edge.
`timescale 1ns/10ps
`default_nettype none

`define CHECK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin $display("ERROR %s expected %h seen %h", nm, ex, got); n_errors++; end end

module testbench;
  // --------------------------------------
  // Signals
  // --------------------------------------
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ready_i = 1'b1;
  logic irq_n_i = 1'b1;
  logic mask_flag_i = 1'b0;
  logic hold_off = 1'b0;
  logic [15:0] pc_i = 16'h0000;
  logic [7:0] status_i = 8'h00;
  logic [7:0] sp_i = 8'h00;
  cpu_bus_pkg::bus_req_s req_i = '0;
  cpu_bus_pkg::bus_rsp_s rsp_o;
  cpu_bus_pkg::irq_done_s irq_done_o;
  logic req_ready_o, data_io_oe_o, write_o, gate, mask_set_o, irq_busy_o, halted_o, phi2_o;
  logic [15:0] addr_out_o;
  logic [7:0] data_io_i, data_io_o, rd;
  int n_errors = 0;
  int num_checks = 0;
  int oe_in_read = 0;
  int oe_seen = 0;
  int halt_in_write = 0;
  int busy_seen = 0;
  int mask_pulses = 0;
  int rsp_cnt = 0;

  always #25 sys_clk_i = ~sys_clk_i;

  cpu_bus_ready_irq_control #(.EXT_CLOCK(1'b0), .HAS_GATE(1'b1), .ADDR_W(16)) dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .phi1_i(1'b0), .phi2_i(1'b0),
    .phi1_o(), .phi2_o(phi2_o), .addr_out_o(addr_out_o), .data_io_i(data_io_i),
    .data_io_o(data_io_o), .data_io_oe_o(data_io_oe_o), .write_o(write_o),
    .data_out_gate_i(gate), .ready_i(ready_i), .irq_n_i(irq_n_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .rsp_o(rsp_o), .mask_flag_i(mask_flag_i), .pc_i(pc_i),
    .status_i(status_i), .sp_i(sp_i), .mask_set_o(mask_set_o), .irq_done_o(irq_done_o),
    .irq_busy_o(irq_busy_o), .halted_o(halted_o));

  bus_memory_model mem_model (
    .sys_clk_i(sys_clk_i), .phi2_i(phi2_o), .addr_i(addr_out_o), .wdata_i(data_io_o),
    .oe_i(data_io_oe_o), .write_i(write_o), .hold_off_i(hold_off), .data_o(data_io_i),
    .gate_o(gate));

  always @(negedge sys_clk_i)
  begin
    if (data_io_oe_o === 1'b1 && write_o !== 1'b1) oe_in_read++;
    if (data_io_oe_o === 1'b1) oe_seen++;
    if (halted_o === 1'b1 && write_o === 1'b1) halt_in_write++;
    if (irq_busy_o === 1'b1) busy_seen++;
    if (mask_set_o === 1'b1) mask_pulses++;
    if (rsp_o.valid === 1'b1) rsp_cnt++;
  end

  // --------------------------------------
  // Shared tasks
  // --------------------------------------
  task automatic report_and_stop();
    if (n_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Selector 0 waits for acceptance, 1 for a response, 2 for interrupt completion.
  task automatic wait_for(input int sel, input int bound);
    int n;
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < bound)
    begin
      @(negedge sys_clk_i);
      n++;
      hit = (sel == 0) ? (req_ready_o === 1'b1) :
            (sel == 1) ? (rsp_o.valid === 1'b1) : (irq_done_o.valid === 1'b1);
    end
    if (!hit)
    begin
      $display("ERROR handshake %0d expected 1 seen 0", sel);
      n_errors++;
      report_and_stop();
    end
  endtask

  task automatic start(input logic wr, input logic lst, input logic [15:0] a,
                       input logic [7:0] d);
    @(posedge sys_clk_i);
    req_i <= '{valid: 1'b1, write: wr, last: lst, addr: a, wdata: d};
    wait_for(0, 40);
    @(posedge sys_clk_i);
    req_i.valid <= 1'b0;
  endtask

  task automatic finish_cycle(input int bound);
    wait_for(1, bound);
    rd = rsp_o.rdata;
  endtask

  // --------------------------------------
  // Scenarios
  // --------------------------------------
  task automatic t_write_read();
    start(1'b1, 1'b0, 16'hC3A5, 8'h5C);
    finish_cycle(30);
    `CHECK("stored byte", 8'h5C, mem_model.mem[16'hC3A5])
    start(1'b0, 1'b0, 16'hC3A5, 8'h00);
    finish_cycle(30);
    `CHECK("read byte", 8'h5C, rd)
    `CHECK("drive in read", 0, oe_in_read)
  endtask

  task automatic t_gate_off();
    mem_model.mem[16'h0040] = 8'h11;
    hold_off <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    oe_seen = 0;
    start(1'b1, 1'b0, 16'h0040, 8'h77);
    finish_cycle(30);
    `CHECK("gated drive", 0, oe_seen)
    `CHECK("gated byte", 8'h11, mem_model.mem[16'h0040])
    hold_off <= 1'b0;
  endtask

  task automatic t_ready_stall();
    int seen;
    ready_i <= 1'b0;
    start(1'b1, 1'b0, 16'h0201, 8'h99);
    finish_cycle(30);
    `CHECK("write under ready low", 8'h99, mem_model.mem[16'h0201])
    `CHECK("halt in write", 0, halt_in_write)
    start(1'b0, 1'b0, 16'hC3A5, 8'h00);
    seen = rsp_cnt;
    repeat (40) @(negedge sys_clk_i);
    `CHECK("halted", 1'b1, halted_o)
    `CHECK("held address", 16'hC3A5, addr_out_o)
    `CHECK("no response while low", seen, rsp_cnt)
    ready_i <= 1'b1;
    finish_cycle(40);
    `CHECK("stalled read", 8'h5C, rd)
  endtask

  task automatic t_irq();
    mem_model.mem[16'hFFFE] = 8'h34;
    mem_model.mem[16'hFFFF] = 8'h12;
    pc_i <= 16'hABCD;
    status_i <= 8'h5A;
    sp_i <= 8'hFF;
    mask_flag_i <= 1'b0;
    irq_n_i <= 1'b0;
    mask_pulses = 0;
    repeat (8) @(posedge sys_clk_i);
    start(1'b0, 1'b1, 16'h0010, 8'h00);
    finish_cycle(40);
    wait_for(2, 120);
    `CHECK("vector", 16'h1234, irq_done_o.pc)
    `CHECK("stack pointer", 8'hFC, irq_done_o.sp)
    `CHECK("push high", 8'hAB, mem_model.mem[16'h01FF])
    `CHECK("push low", 8'hCD, mem_model.mem[16'h01FE])
    `CHECK("push status", 8'h5A, mem_model.mem[16'h01FD])
    `CHECK("mask pulses", 1, mask_pulses)
    irq_n_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
  endtask

  task automatic t_irq_held_off();
    irq_n_i <= 1'b0;
    mask_flag_i <= 1'b1;
    // Let the request reach the pending flag, so the mask check can trip.
    repeat (12) @(posedge sys_clk_i);
    busy_seen = 0;
    start(1'b0, 1'b1, 16'h0011, 8'h00);
    finish_cycle(40);
    repeat (30) @(negedge sys_clk_i);
    `CHECK("masked busy", 0, busy_seen)
    mask_flag_i <= 1'b0;
    start(1'b0, 1'b0, 16'h0012, 8'h00);
    finish_cycle(40);
    repeat (30) @(negedge sys_clk_i);
    `CHECK("mid instruction busy", 0, busy_seen)
    irq_n_i <= 1'b1;
  endtask

  initial
  begin
    repeat (8) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    t_write_read();
    t_gate_off();
    t_ready_stall();
    t_irq();
    t_irq_held_off();
    report_and_stop();
  end
endmodule

`default_nettype wire
